// File: ivc_core.sv
// interrupt vector controller: arbitration and vector address generation
`timescale 1ns/1ps
module ivc_core
  import ivc_pkg::*;
#(
  parameter int NUM_SRC = 50,
  parameter int PAGE_SHIFT = 10
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [9:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [NUM_SRC-1:0] i_irq,
  input wire logic [IVC_NUM_TRAPS-1:0] i_trap,
  input wire logic i_bs_defined,
  input wire logic i_alt_table_disable_config_bit,
  input wire logic [12:0] i_boot_segment_limit_field,
  input wire logic [12:0] i_bs_pages,
  input wire logic i_bs_protect,
  input wire logic i_ack,
  input wire logic i_ret,
  output logic o_irq_req,
  output logic [23:0] o_vec_addr,
  output logic [7:0] o_vec_num,
  output logic [2:0] o_vec_lvl,
  output logic o_vec_is_trap,
  output logic o_vec_protect,
  output logic o_entry_done,
  output logic o_ret_done,
  output logic o_fetch_valid,
  output logic [23:0] o_fetch_addr
);

  // ****************************************************************
  // state and priority memory
  // ****************************************************************
  ivc_regs_t r_q;
  ivc_regs_t r_d;
  // store answer, one cycle behind the index it was asked for
  logic [2:0] prio_rd;
  logic prio_we;
  logic [5:0] prio_widx;
  logic alt_ok;
  logic [23:0] table_base;
  logic trap_any;

  // priority writes land in the memory directly
  assign prio_we = i_wr && (i_addr >= IVC_PRIO_OFF) &&
                   (i_addr < IVC_PRIO_END);
  assign prio_widx = i_addr[7:2];

  // write-only words: a read of them answers zero
  // no reset on the array: every level is written before glb enable
  ivc_prio_mem #(
    .DEPTH(IVC_MAX_SRC),
    .AW(6)
  ) u_prio (
    .i_clock(i_clock),
    .i_we(prio_we),
    .i_waddr(prio_widx),
    .i_wdata(i_wdata[2:0]),
    .i_raddr(r_q.idx),
    .o_rdata(prio_rd)
  );

  // ****************************************************************
  // table base selection
  // ****************************************************************
  // alternate table only with segment, config bit, enable, two pages
  assign alt_ok = i_bs_defined && i_alt_table_disable_config_bit &&
                  r_q.alt_en &&
                  (i_bs_pages >= 13'(IVC_MIN_BS_PAGES));
  // last boot page start, else the default table at zero
  // limitation: PAGE_SHIFT above 11 pushes the base past 24 bits
  assign table_base = alt_ok ?
    (24'(i_boot_segment_limit_field) << PAGE_SHIFT) :
    24'h000000;
  // any trap pending outranks every source at decide
  assign trap_any = |r_q.trap_pend;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [2:0] lvl;
    logic hit;
    logic [7:0] win;
    int k;
    // scratch values first, so no path leaves one unassigned
    lvl = prio_rd;
    hit = 1'b0;
    win = 8'h00;
    k = 0;
    r_d = r_q;
    r_d.entry_done = 1'b0;
    r_d.ret_done = 1'b0;
    r_d.fetch_v = 1'b0;
    r_d.rdata = 32'h00000000;
    r_d.protect = i_bs_protect;

    // register writes
    if (i_wr) begin
      if (i_addr == IVC_CTRL_OFF) begin
        r_d.alt_en = i_wdata[IVC_ALT_EN_BIT];
        r_d.glb_en = i_wdata[IVC_GLB_EN_BIT];
        r_d.cpu_ipl = i_wdata[IVC_IPL_LSB +: 3];
      end else if (i_addr == IVC_EN_LO_OFF) begin
        r_d.enable[31:0] = i_wdata;
      end else if (i_addr == IVC_EN_HI_OFF) begin
        r_d.enable[63:32] = i_wdata;
      end
    end

    // register reads, data stand one cycle later
    if (i_rd) begin
      if (i_addr == IVC_CTRL_OFF) begin
        r_d.rdata[IVC_ALT_EN_BIT] = r_q.alt_en;
        r_d.rdata[IVC_GLB_EN_BIT] = r_q.glb_en;
        r_d.rdata[IVC_IPL_LSB +: 3] = r_q.cpu_ipl;
      end else if (i_addr == IVC_EN_LO_OFF) begin
        r_d.rdata = r_q.enable[31:0];
      end else if (i_addr == IVC_EN_HI_OFF) begin
        r_d.rdata = r_q.enable[63:32];
      end else if (i_addr == IVC_STAT_OFF) begin
        r_d.rdata = {8'h00, 1'b0, r_q.st, alt_ok, r_q.out.lvl,
                     2'b00, r_q.trap_pend, r_q.out.vec};
      end
    end

    // main sequencer
    case (r_q.st)
      // reset fetches the jump, then its target word
      IVC_ST_RST0: begin
        r_d.fetch_v = 1'b1;
        r_d.fetch_addr = IVC_RESET_GOTO_ADDR;
        r_d.st = IVC_ST_RST1;
      end
      IVC_ST_RST1: begin
        r_d.fetch_v = 1'b1;
        r_d.fetch_addr = IVC_RESET_TGT_ADDR;
        // arbitration starts clean once both reset words are out
        r_d.st = IVC_ST_SCAN;
        r_d.idx = 6'h00;
        r_d.idx_v = 1'b0;
        r_d.best_v = 1'b0;
      end
      // one source per cycle, the full list unless a return cuts in
      IVC_ST_SCAN: begin
        if (r_q.idx_v) begin
          // masked and level-zero sources never win
          hit = i_irq[r_q.prev] && r_q.enable[r_q.prev] &&
                r_q.glb_en && (lvl != 3'h0) &&
                (lvl > r_q.cpu_ipl);
          // strict greater keeps the lower index on a tie
          if (hit && (!r_q.best_v || lvl > r_q.best_lvl)) begin
            r_d.best_v = 1'b1;
            r_d.best_lvl = lvl;
            r_d.best_vec = 8'(r_q.prev) + IVC_IRQ_VEC_BASE;
          end
        end
        // the store answers late, so the previous index is judged
        r_d.prev = r_q.idx;
        r_d.idx_v = (r_q.idx < 6'(NUM_SRC));
        // the last index only flushes the store pipeline
        if (r_q.idx == 6'(NUM_SRC)) begin
          r_d.st = IVC_ST_DECIDE;
        end else begin
          r_d.idx = r_q.idx + 6'h01;
        end
        // a return cuts the pass short; it restarts from source zero
        if (i_ret) begin
          r_d.st = IVC_ST_RETURN;
          r_d.cnt = 8'h00;
        end
      end
      // traps outrank every source, lowest slot first
      IVC_ST_DECIDE: begin
        // a fresh pass follows whether or not anything won
        r_d.idx = 6'h00;
        r_d.idx_v = 1'b0;
        r_d.best_v = 1'b0;
        r_d.st = IVC_ST_SCAN;
        if (trap_any) begin
          // walk down so the lowest pending slot is taken last
          for (k = IVC_NUM_TRAPS - 1; k >= 0; k--) begin
            if (r_q.trap_pend[k]) begin
              win = IVC_TRAP_VEC[k];
              r_d.trap_sel = '0;
              r_d.trap_sel[k] = 1'b1;
            end
          end
          r_d.out.trap = 1'b1;
          r_d.out.lvl = 3'h7;
        end else begin
          win = r_q.best_vec;
          r_d.trap_sel = '0;
          r_d.out.trap = 1'b0;
          r_d.out.lvl = r_q.best_lvl;
        end
        // request raised only when something won
        if (trap_any || r_q.best_v) begin
          r_d.out.req = 1'b1;
          r_d.out.vec = win;
          // base plus table start plus two per vector
          r_d.out.addr = table_base + IVC_TABLE_START +
                         {15'h0000, win, 1'b0};
          r_d.st = IVC_ST_PRESENT;
        end
      end
      // core fetches the 24-bit handler address on acknowledge
      IVC_ST_PRESENT: begin
        // the vector stays put even if its source has dropped meanwhile
        if (i_ack) begin
          r_d.out.req = 1'b0;
          r_d.fetch_v = 1'b1;
          r_d.fetch_addr = r_q.out.addr;
          r_d.cnt = 8'h00;
          r_d.st = IVC_ST_ENTRY;
        end
      end
      // fixed entry time whatever the source
      IVC_ST_ENTRY: begin
        r_d.cnt = r_q.cnt + 8'h01;
        if (r_q.cnt == IVC_ENTRY_CYCLES - 8'h01) begin
          r_d.entry_done = 1'b1;
          r_d.st = IVC_ST_SCAN;
          r_d.idx = 6'h00;
          r_d.idx_v = 1'b0;
          // the next pass starts clean, as after a return
          r_d.best_v = 1'b0;
        end
      end
      // fixed return time
      // a return seen outside a pass is dropped
      IVC_ST_RETURN: begin
        r_d.cnt = r_q.cnt + 8'h01;
        if (r_q.cnt == IVC_RETURN_CYCLES - 8'h01) begin
          r_d.ret_done = 1'b1;
          r_d.st = IVC_ST_SCAN;
          r_d.idx = 6'h00;
          r_d.idx_v = 1'b0;
          r_d.best_v = 1'b0;
        end
      end
      default: begin
        r_d.st = IVC_ST_SCAN;
      end
    endcase

    // trap pending: clear on acknowledge, a new event wins
    if (r_q.st == IVC_ST_PRESENT && i_ack) begin
      r_d.trap_pend = r_q.trap_pend & ~r_q.trap_sel;
    end
    r_d.trap_pend = r_d.trap_pend | i_trap;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // async clear: all state zero, boot fetch pair follows release
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register
  assign o_rdata = r_q.rdata;
  assign o_irq_req = r_q.out.req;
  assign o_vec_addr = r_q.out.addr;
  assign o_vec_num = r_q.out.vec;
  assign o_vec_lvl = r_q.out.lvl;
  assign o_vec_is_trap = r_q.out.trap;
  assign o_vec_protect = r_q.protect;
  assign o_entry_done = r_q.entry_done;
  assign o_ret_done = r_q.ret_done;
  assign o_fetch_valid = r_q.fetch_v;
  assign o_fetch_addr = r_q.fetch_addr;

endmodule

// File: ivc_core_properties.sv
// port-level assertions for the vector controller
`timescale 1ns/1ps
module ivc_core_properties
  import ivc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_bs_defined,
  input wire logic i_alt_table_disable_config_bit,
  input wire logic [12:0] i_bs_pages,
  input wire logic i_bs_protect,
  input wire logic i_ack,
  input wire logic o_irq_req,
  input wire logic [23:0] o_vec_addr,
  input wire logic [7:0] o_vec_num,
  input wire logic [2:0] o_vec_lvl,
  input wire logic o_vec_is_trap,
  input wire logic o_vec_protect,
  input wire logic o_entry_done,
  input wire logic o_fetch_valid,
  input wire logic [23:0] o_fetch_addr
);
  // ****************************************************************
  // vector link, boot fetch and read data checks
  // ****************************************************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_take;
    o_irq_req && i_ack;
  endsequence
  property p_fetch;
    s_take |=> !o_irq_req && o_fetch_valid && o_fetch_addr == $past(o_vec_addr);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("vector fetch missing after ack");
  property p_entry;
    s_take |=> (!o_entry_done)[*8] ##1 (!o_entry_done)[*2]
      ##1 o_entry_done;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry time wrong");
  property p_hold;
    o_irq_req && !i_ack |=> o_irq_req && $stable(o_vec_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped before ack");
  property p_slot;
    o_irq_req |-> o_vec_addr[9:0] == 10'h004 + {o_vec_num, 1'b0};
  endproperty
  a_slot: assert property (p_slot)
    else $error("slot offset wrong");
  property p_alt_off;
    o_irq_req && (!i_bs_defined || !i_alt_table_disable_config_bit ||
      i_bs_pages < 13'h0002) |-> o_vec_addr[23:10] == 14'h0000;
  endproperty
  a_alt_off: assert property (p_alt_off)
    else $error("alternate base used while not allowed");
  property p_kind;
    o_irq_req |-> (o_vec_is_trap ? (o_vec_num <= 8'h06 && o_vec_num != 8'h05
      && o_vec_lvl == 3'h7) : (o_vec_num >= 8'h08 && o_vec_lvl != 3'h0));
  endproperty
  a_kind: assert property (p_kind)
    else $error("vector number or level out of range");
  property p_prot;
    o_irq_req |-> o_vec_protect == i_bs_protect;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protection not inherited");
  property p_boot;
    $fell(i_rst) |=> o_fetch_valid && o_fetch_addr == 24'h000000 ##1
      o_fetch_valid && o_fetch_addr == 24'h000002;
  endproperty
  a_boot: assert property (p_boot)
    else $error("reset entry fetch wrong");
  property p_rdata;
    !$past(i_rd) |-> o_rdata == 32'h00000000;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside read cycle");
endmodule
bind ivc_core ivc_core_properties ivc_core_properties_i (.i_clock, .i_rst,
  .i_rd, .o_rdata, .i_bs_defined, .i_alt_table_disable_config_bit,
  .i_bs_pages, .i_bs_protect, .i_ack, .o_irq_req, .o_vec_addr, .o_vec_num,
  .o_vec_lvl, .o_vec_is_trap, .o_vec_protect, .o_entry_done, .o_fetch_valid,
  .o_fetch_addr);

// File: ivc_core_test.sv
// randomised self-checking bench for the vector controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module ivc_core_test
  import ivc_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [9:0] i_addr = 10'h000;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [49:0] i_irq = 50'h0;
  logic [5:0] i_trap = 6'h00;
  logic i_bs_defined = 1'b0;
  logic i_alt_table_disable_config_bit = 1'b0;
  logic [12:0] i_boot_segment_limit_field = 13'h0000;
  logic [12:0] i_bs_pages = 13'h0000;
  logic i_bs_protect = 1'b0;
  logic i_ack, i_ret, o_irq_req, o_vec_is_trap, o_vec_protect;
  logic o_entry_done, o_ret_done, o_fetch_valid;
  logic [31:0] o_rdata;
  logic [23:0] o_vec_addr, o_fetch_addr;
  logic [7:0] o_vec_num;
  logic [2:0] o_vec_lvl;
  logic [2:0] prio [50];
  logic [49:0] pend = 50'h0;
  logic [49:0] en = 50'h0;
  logic [5:0] tpend = 6'h00;
  logic [31:0] ctrl = 32'h0;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ret_at = 0;
  int n_ret = 0;
  int n_ret_done = 0;
  ivc_core #(.NUM_SRC(50), .PAGE_SHIFT(10)) ivc_core_i (.i_clock, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_irq, .i_trap,
    .i_bs_defined, .i_alt_table_disable_config_bit,
    .i_boot_segment_limit_field, .i_bs_pages, .i_bs_protect, .i_ack, .i_ret,
    .o_irq_req, .o_vec_addr, .o_vec_num, .o_vec_lvl, .o_vec_is_trap,
    .o_vec_protect, .o_entry_done, .o_ret_done, .o_fetch_valid,
    .o_fetch_addr);
  ivc_cpu_model ivc_cpu_model_i (.i_clock, .i_rst, .i_irq_req(o_irq_req),
    .i_entry_done(o_entry_done), .o_ack(i_ack), .o_ret(i_ret));
  // ****************************************************************
  // bus tasks and expectation helpers
  // ****************************************************************
  always #4 i_clock = ~i_clock;
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 `CHK("rdata", e, o_rdata)
    @(posedge i_clock);
  endtask
  // traps first, then highest level, then lowest source index
  function automatic void predict(output logic [7:0] v, output logic [2:0] l,
    output logic t);
    t = 1'b0;
    v = 8'h00;
    l = 3'h0;
    for (int k = 5; k >= 0; k--) if (tpend[k]) begin
      t = 1'b1;
      v = IVC_TRAP_VEC[k];
      l = 3'h7;
    end
    if (!t) for (int n = 49; n >= 0; n--) if (pend[n] && en[n] && ctrl[0] &&
      prio[n] != 3'h0 && prio[n] > ctrl[6:4] && prio[n] >= l) begin
      v = 8'(n) + IVC_IRQ_VEC_BASE;
      l = prio[n];
    end
  endfunction
  function automatic logic [23:0] exp_addr(input logic [7:0] v);
    logic [23:0] b;
    b = (ctrl[8] && i_bs_defined && i_alt_table_disable_config_bit &&
      i_bs_pages >= 13'h0002) ? 24'(i_boot_segment_limit_field) << 10 : 24'h0;
    return b + IVC_TABLE_START + {15'h0, v, 1'b0};
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, well beyond the expected run length
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  // return latency from the pulses at the pins, seven edges apart
  always @(posedge i_clock) begin
    cyc++;
    if (i_ret === 1'b1) begin
      ret_at = cyc;
      n_ret++;
    end
    if (o_ret_done === 1'b1) begin
      n_ret_done++;
      `CHK("ret_lat", 7, cyc - ret_at)
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] ev;
    logic [2:0] el;
    logic et;
    logic [5:0] t;
    int n;
    void'($urandom(44));
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    #1 `CHK("boot0", 25'h1000000, {o_fetch_valid, o_fetch_addr})
    @(posedge i_clock);
    #1 `CHK("boot1", 25'h1000002, {o_fetch_valid, o_fetch_addr})
    @(posedge i_clock);
    for (n = 0; n < 50; n++) begin
      prio[n] = 3'($urandom_range(7));
      wr(10'h100 + 10'(4 * n), {29'h0, prio[n]});
    end
    en = 50'({$urandom(), $urandom()});
    wr(10'h004, en[31:0]);
    wr(10'h008, {14'h0000, en[49:32]});
    rd(10'h004, en[31:0]);
    rd(10'h008, {14'h0000, en[49:32]});
    rd(10'h104, 32'h00000000);
    rd(10'h3FC, 32'h00000000);
    ctrl = 32'h00000001;
    wr(10'h000, ctrl);
    tpend = 6'h3F;
    i_trap <= 6'h3F;
    @(posedge i_clock);
    i_trap <= 6'h00;
    for (int r = 0; r < 60; r++) begin
      n = 0;
      do begin
        @(posedge i_clock);
        #1 n++;
      end while (o_irq_req !== 1'b1 && n < 400);
      predict(ev, el, et);
      `CHK("vec", ev, o_vec_num)
      `CHK("lvl", el, o_vec_lvl)
      `CHK("trap", et, o_vec_is_trap)
      `CHK("addr", exp_addr(ev), o_vec_addr)
      while (i_ack !== 1'b1) begin
        @(posedge i_clock);
        #1;
      end
      // new stimulus only while the entry runs, so every scan sees it whole
      @(posedge i_clock);
      if (et) tpend[ev == 8'h06 ? 3'h5 : ev[2:0]] = 1'b0;
      else pend[6'(ev - IVC_IRQ_VEC_BASE)] = 1'b0;
      if (r == 15) begin
        // corner: alternate table allowed at the smallest segment size
        ctrl = 32'h00000101;
        {i_bs_defined, i_alt_table_disable_config_bit, i_bs_protect} <= 3'h7;
        i_bs_pages <= 13'h0002;
        i_boot_segment_limit_field <= 13'($urandom());
      end else if (r % 8 == 7) begin
        ctrl = $urandom() & 32'h00000171;
        {i_bs_defined, i_alt_table_disable_config_bit, i_bs_protect} <=
          3'($urandom());
        i_bs_pages <= 13'($urandom_range(3));
        i_boot_segment_limit_field <= 13'($urandom());
      end
      t = 6'($urandom()) & {6{$urandom_range(3) == 0}};
      pend = pend | (50'({$urandom(), $urandom()}) &
        50'({$urandom(), $urandom()}));
      tpend = tpend | t;
      predict(ev, el, et);
      if (!et && el == 3'h0) t[5] = 1'b1;
      tpend = tpend | t;
      i_irq <= pend;
      i_trap <= t;
      @(posedge i_clock);
      i_trap <= 6'h00;
      if (r % 8 == 7) begin
        wr(10'h000, ctrl);
        rd(10'h000, ctrl);
      end
    end
    `CHK("ret_seen", 1'b1, n_ret > 0)
    `CHK("ret_count", n_ret, n_ret_done)
    print_verdict();
  end
endmodule

// File: ivc_cpu_model.sv
// behavioural core: acks vectors, returns from handlers
`timescale 1ns/1ps
module ivc_cpu_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_irq_req,
  input wire logic i_entry_done,
  output logic o_ack,
  output logic o_ret
);
  int wait_q;
  int ret_q;
  // random stall before ack, return a few cycles into the handler
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_ret <= 1'b0;
      wait_q <= 0;
      ret_q <= 0;
    end else begin
      o_ack <= 1'b0;
      o_ret <= 1'b0;
      if (i_irq_req && !o_ack) begin
        if (wait_q == 0) begin
          o_ack <= 1'b1;
          wait_q <= $urandom_range(4);
        end else begin
          wait_q <= wait_q - 1;
        end
      end
      if (i_entry_done) begin
        ret_q <= 1 + $urandom_range(2);
      end else if (ret_q == 1) begin
        o_ret <= 1'b1;
        ret_q <= 0;
      end else if (ret_q > 1) begin
        ret_q <= ret_q - 1;
      end
    end
  end
endmodule

// File: ivc_pkg.sv
// shared constants, states and state record for the vector controller
package ivc_pkg;

  // ****************************************************************
  // table layout (word addresses in program memory)
  // ****************************************************************
  localparam logic [23:0] IVC_RESET_GOTO_ADDR = 24'h000000;
  localparam logic [23:0] IVC_RESET_TGT_ADDR = 24'h000002;
  localparam logic [23:0] IVC_TABLE_START = 24'h000004;
  localparam logic [23:0] IVC_IRQ0_OFFSET = 24'h000014;
  localparam logic [23:0] IVC_LAST_OFFSET = 24'h0001FE;
  localparam logic [23:0] IVC_CODE_START = 24'h000200;
  localparam logic [7:0] IVC_IRQ_VEC_BASE = 8'h08;
  localparam int IVC_NUM_TRAPS = 6;
  localparam int IVC_LEVELS = 7;
  localparam logic [1:0] IVC_MIN_BS_PAGES = 2'h2;
  localparam int IVC_MAX_SRC = 64;
  localparam int IVC_ALT_EN_BIT = 8;
  localparam int IVC_GLB_EN_BIT = 0;
  localparam int IVC_IPL_LSB = 4;

  // trap vector numbers, slot offset is table start plus two per number
  localparam logic [7:0] IVC_TRAP_VEC [IVC_NUM_TRAPS] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06};

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [9:0] IVC_CTRL_OFF = 10'h000;
  localparam logic [9:0] IVC_EN_LO_OFF = 10'h004;
  localparam logic [9:0] IVC_EN_HI_OFF = 10'h008;
  localparam logic [9:0] IVC_STAT_OFF = 10'h00C;
  localparam logic [9:0] IVC_PRIO_OFF = 10'h100;
  localparam logic [9:0] IVC_PRIO_END = 10'h200;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam logic [7:0] IVC_ENTRY_CYCLES = 8'h0A;
  localparam logic [7:0] IVC_RETURN_CYCLES = 8'h06;

  typedef enum logic [2:0] {
    IVC_ST_RST0 = 3'b000,
    IVC_ST_RST1 = 3'b001,
    IVC_ST_SCAN = 3'b010,
    IVC_ST_DECIDE = 3'b011,
    IVC_ST_PRESENT = 3'b100,
    IVC_ST_ENTRY = 3'b101,
    IVC_ST_RETURN = 3'b110
  } ivc_state_t;

  // outward request to the core
  typedef struct packed {
    logic req;
    logic [23:0] addr;
    logic [7:0] vec;
    logic [2:0] lvl;
    logic trap;
  } ivc_vec_req_t;

  typedef struct packed {
    ivc_state_t st;
    logic [5:0] idx;
    logic idx_v;
    logic [5:0] prev;
    logic [2:0] best_lvl;
    logic [7:0] best_vec;
    logic best_v;
    logic [IVC_NUM_TRAPS-1:0] trap_pend;
    logic [IVC_NUM_TRAPS-1:0] trap_sel;
    logic alt_en;
    logic glb_en;
    logic [2:0] cpu_ipl;
    logic [IVC_MAX_SRC-1:0] enable;
    ivc_vec_req_t out;
    logic [7:0] cnt;
    logic [31:0] rdata;
    logic protect;
    logic entry_done;
    logic ret_done;
    logic fetch_v;
    logic [23:0] fetch_addr;
  } ivc_regs_t;

endpackage

// File: ivc_prio_mem.sv
// per-source priority store, registered read port
`timescale 1ns/1ps
module ivc_prio_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [2:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [2:0] o_rdata
);

  logic [2:0] mem_q [DEPTH];

  // write port and registered read, no reset on the array
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end

endmodule
